// [design/rsc_pkg.sv]
// Purpose: shared constants and types of the reset source control block
// Assumes: 40 MHz reference clock, one slow sub-clock tick input
// Notes:   register offsets are word indices on the plain register port

package rsc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned RELEASE_POR_NS = 50_000_000;
	localparam int unsigned RELEASE_WDT_NS = 16_700_000;
	localparam int unsigned RELEASE_POR_CYC = RELEASE_POR_NS / CLK_PERIOD_NS;
	localparam int unsigned RELEASE_WDT_CYC = RELEASE_WDT_NS / CLK_PERIOD_NS;
	localparam int unsigned LV_FILTER_NS = 1000;
	localparam int unsigned LV_FILTER_CYC = (LV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FAULT_SUB_TICKS = 2;
	localparam int unsigned WAKE_FAST_CYC = 16;
	localparam int unsigned WAKE_SLOW_XTAL_CYC = 1024;
	localparam int unsigned WAKE_SLOW_INT_CYC = 2;
	localparam int unsigned HOLD_W = 21;
	localparam int unsigned FILT_W = 16;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 2;
	localparam logic [1:0] OFS_THRESHOLD = 2'h0;
	localparam logic [1:0] OFS_CAUSE_CTRL = 2'h1;
	localparam logic [1:0] OFS_STATUS = 2'h2;
	localparam logic [7:0] THR_POR = 8'h55;
	localparam logic [7:0] THR_2V55 = 8'h33;
	localparam logic [7:0] THR_3V15 = 8'h99;
	localparam logic [7:0] THR_3V80 = 8'haa;
	localparam logic [4:0] WDC_DISABLE = 5'h15;
	localparam logic [4:0] WDC_ENABLE = 5'h0a;
	localparam int unsigned CTRL_KEEP_BIT = 7;
	localparam int unsigned CTRL_SUBF_BIT = 3;
	localparam int unsigned CTRL_LVF_BIT = 2;
	localparam int unsigned CTRL_THRF_BIT = 1;
	localparam int unsigned CTRL_WDCF_BIT = 0;
	localparam int unsigned STAT_TO_BIT = 5;
	localparam int unsigned STAT_PDF_BIT = 4;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RSC_WAKE_FAST_INT,
		RSC_WAKE_FAST_XTAL,
		RSC_WAKE_SLOW_XTAL,
		RSC_WAKE_SLOW_INT
	} rsc_wake_src_t;

	typedef enum logic [1:0] {
		RSC_CAUSE_LV,
		RSC_CAUSE_THR,
		RSC_CAUSE_WDC,
		RSC_CAUSE_WDT
	} rsc_cause_t;

endpackage

// [design/rsc_top.sv]
// Purpose: reset source control: power-on, low supply, threshold and watchdog resets
// Assumes: all inputs synchronous to i_ref_clk; i_sub_tick pulses once per sub-clock
// Notes:   i_reset is the power-on reset itself
//
// Behaviour
// - power-on: core reset asserted, ports preset high, fetch starts at zero
// - power-on and low-supply resets hold core reset about 50 ms
// - low-supply reset armed except in power-down; resets device and sets low-voltage flag
// - low supply must outlast the filter time; shorter dips are ignored
// - threshold field legal codes: 55, 33, 99, aa hex
// - illegal threshold code: reset after 2-3 sub-clocks, field restored, fault flag
// - genuine low supply: reset after 2-3 sub-clocks, threshold kept
// - low-supply reset disabled while in power-down
// - threshold register powers up as 55 hex, lowest threshold
// - cause register bits 6 to 4 read zero
// - low-voltage flag in bit 2: software clears, never sets
// - threshold fault flag in bit 1 set by hardware, cleared by writing 0
// - watchdog overflow in normal mode: full reset plus timeout flag
// - watchdog full reset holds core reset about 16.7 ms
// - watchdog overflow in sleep/idle: only pc and sp cleared, timeout set
// - wake settle: 16 fast, 1024 slow crystal, 2 slow internal clocks
// - flags: power-on clears both; low supply keeps; watchdog sets per mode
// - power-on default pulse: interrupts off, watchdog cleared, timers off, sp top
// - illegal watchdog enable code: reset after 2-3 sub-clocks, fault flag set
//
// The address map and the plain strobed port were decided locally.

`timescale 1ns/1ps
`default_nettype none

module rsc_top #(
	parameter int unsigned POR_HOLD_CYC = rsc_pkg::RELEASE_POR_CYC,
	parameter int unsigned WDT_HOLD_CYC = rsc_pkg::RELEASE_WDT_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [rsc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sub_tick,
	input wire logic i_supply_low,
	input wire logic i_powerdown,
	input wire logic i_halt_mode,
	input wire logic i_wdt_overflow,
	input wire logic [4:0] i_wdt_enable_code,
	input wire logic i_subclk_fault,
	input wire rsc_pkg::rsc_wake_src_t i_wake_src,
	output logic o_core_reset,
	output logic o_por_active,
	output logic o_por_defaults,
	output logic o_pc_sp_reset,
	output logic o_wake_hold,
	output logic [1:0] o_threshold_sel,
	output logic o_sysclk_keep_idle
);
	import rsc_pkg::*;

	typedef enum logic [1:0] {ST_RUN, ST_ARM, ST_HOLD, ST_SETTLE} rsc_state_t;

	rsc_state_t st_q;
	rsc_cause_t cause_q;
	rsc_cause_t arm_cause;
	logic [1:0] sub_cnt_q;
	logic [HOLD_W-1:0] hold_cnt_q;
	logic [HOLD_W-1:0] settle_load;
	logic [FILT_W-1:0] lv_cnt_q;
	logic [7:0] thr_q;
	logic lv_flag_q;
	logic thr_flag_q;
	logic wdc_flag_q;
	logic subf_flag_q;
	logic to_q;
	logic pdf_q;
	logic thr_legal;
	logic wdc_legal;
	logic lv_hit;
	logic arm_req;
	logic hold_enter;
	logic hold_done;
	logic wdt_full;
	logic wdt_halt;
	logic set_lv;
	logic set_thr;
	logic set_wdc;
	logic thr_wr;
	logic ctrl_wr;

	// ----------------------------------------------------------------
	// reset source detection
	// ----------------------------------------------------------------
	always_comb begin
		thr_legal = (thr_q == THR_POR) || (thr_q == THR_2V55)
			|| (thr_q == THR_3V15) || (thr_q == THR_3V80);
		wdc_legal = (i_wdt_enable_code == WDC_ENABLE) || (i_wdt_enable_code == WDC_DISABLE);
		// comparator is masked in power-down, so no dip can arm a reset there
		lv_hit = i_supply_low && !i_powerdown && (lv_cnt_q == FILT_W'(LV_FILTER_CYC));
		arm_req = (st_q == ST_RUN) && (!thr_legal || !wdc_legal || lv_hit);
		if (!thr_legal) begin
			arm_cause = RSC_CAUSE_THR;
		end else if (!wdc_legal) begin
			arm_cause = RSC_CAUSE_WDC;
		end else begin
			arm_cause = RSC_CAUSE_LV;
		end
		hold_enter = (st_q == ST_ARM) && i_sub_tick
			&& (sub_cnt_q == 2'(FAULT_SUB_TICKS));
		hold_done = (st_q == ST_HOLD || st_q == ST_SETTLE) && (hold_cnt_q == '0);
		wdt_full = (st_q == ST_RUN) && !arm_req && i_wdt_overflow && !i_halt_mode;
		wdt_halt = (st_q == ST_RUN) && !arm_req && i_wdt_overflow && i_halt_mode;
		set_lv = hold_enter && (cause_q == RSC_CAUSE_LV);
		set_thr = hold_enter && (cause_q == RSC_CAUSE_THR);
		set_wdc = hold_enter && (cause_q == RSC_CAUSE_WDC);
		thr_wr = i_wr && (i_addr == OFS_THRESHOLD);
		ctrl_wr = i_wr && (i_addr == OFS_CAUSE_CTRL);
	end

	// slow crystal needs longest to settle after a halted wake-up, slow internal least
	always_comb begin
		unique case (i_wake_src)
			RSC_WAKE_FAST_INT, RSC_WAKE_FAST_XTAL: settle_load = HOLD_W'(WAKE_FAST_CYC - 1);
			RSC_WAKE_SLOW_XTAL: settle_load = HOLD_W'(WAKE_SLOW_XTAL_CYC - 1);
			RSC_WAKE_SLOW_INT: settle_load = HOLD_W'(WAKE_SLOW_INT_CYC - 1);
		endcase
	end

	// low supply filter: counts consecutive low cycles, saturates at the limit
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_supply_low || i_powerdown || st_q != ST_RUN) begin
			lv_cnt_q <= '0;
		end else if (lv_cnt_q != FILT_W'(LV_FILTER_CYC)) begin
			lv_cnt_q <= lv_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			st_q <= ST_HOLD;
			cause_q <= RSC_CAUSE_LV;
			sub_cnt_q <= '0;
			hold_cnt_q <= HOLD_W'(POR_HOLD_CYC - 1);
		end else begin
			unique case (st_q)
				ST_RUN: begin
					if (arm_req) begin
						st_q <= ST_ARM;
						cause_q <= arm_cause;
						sub_cnt_q <= '0;
					end else if (wdt_halt) begin
						st_q <= ST_SETTLE;
						hold_cnt_q <= settle_load;
					end else if (wdt_full) begin
						st_q <= ST_HOLD;
						cause_q <= RSC_CAUSE_WDT;
						hold_cnt_q <= HOLD_W'(WDT_HOLD_CYC - 1);
					end
				end
				// tick phase is free: two ticks can land only 1 period out, so wait for the third
				ST_ARM: begin
					if (hold_enter) begin
						st_q <= ST_HOLD;
						hold_cnt_q <= HOLD_W'(POR_HOLD_CYC - 1);
					end else if (i_sub_tick) begin
						sub_cnt_q <= sub_cnt_q + 1'b1;
					end
				end
				ST_HOLD, ST_SETTLE: begin
					if (hold_done) begin
						st_q <= ST_RUN;
					end else begin
						hold_cnt_q <= hold_cnt_q - 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// reset outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_core_reset <= 1'b1;
		end else begin
			o_core_reset <= hold_enter || wdt_full || (st_q == ST_HOLD && !hold_done);
		end
	end

	// marks a power-on hold, where pointers and accumulator are left undefined
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_por_active <= 1'b1;
		end else if (hold_done) begin
			o_por_active <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		o_por_defaults <= i_reset;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_pc_sp_reset <= 1'b0;
			o_wake_hold <= 1'b0;
		end else begin
			o_pc_sp_reset <= wdt_halt;
			o_wake_hold <= wdt_halt || (st_q == ST_SETTLE && !hold_done);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (thr_q == THR_2V55) begin
			o_threshold_sel <= 2'h1;
		end else if (thr_q == THR_3V15) begin
			o_threshold_sel <= 2'h2;
		end else if (thr_q == THR_3V80) begin
			o_threshold_sel <= 2'h3;
		end else begin
			o_threshold_sel <= 2'h0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			thr_q <= THR_POR;
		end else if (set_thr) begin
			thr_q <= THR_POR;
		end else if (thr_wr) begin
			thr_q <= i_wdata;
		end
	end

	// flags clear only by software or power-on; a hardware set in the same cycle wins
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_sysclk_keep_idle <= 1'b0;
			subf_flag_q <= 1'b0;
			lv_flag_q <= 1'b0;
			thr_flag_q <= 1'b0;
			wdc_flag_q <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				o_sysclk_keep_idle <= i_wdata[CTRL_KEEP_BIT];
				subf_flag_q <= subf_flag_q && i_wdata[CTRL_SUBF_BIT];
				lv_flag_q <= lv_flag_q && i_wdata[CTRL_LVF_BIT];
				thr_flag_q <= thr_flag_q && i_wdata[CTRL_THRF_BIT];
				wdc_flag_q <= wdc_flag_q && i_wdata[CTRL_WDCF_BIT];
			end
			if (i_subclk_fault) begin
				subf_flag_q <= 1'b1;
			end
			if (set_lv) begin
				lv_flag_q <= 1'b1;
			end
			if (set_thr) begin
				thr_flag_q <= 1'b1;
			end
			if (set_wdc) begin
				wdc_flag_q <= 1'b1;
			end
		end
	end

	// low supply and fault resets leave timeout and power-down untouched
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			to_q <= 1'b0;
			pdf_q <= 1'b0;
		end else if (wdt_halt) begin
			to_q <= 1'b1;
			pdf_q <= 1'b1;
		end else if (wdt_full) begin
			to_q <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_rd) begin
			o_rdata <= 8'h00;
		end else begin
			unique case (i_addr)
				OFS_THRESHOLD: o_rdata <= thr_q;
				OFS_CAUSE_CTRL: o_rdata <= {o_sysclk_keep_idle, 3'h0, subf_flag_q,
					lv_flag_q, thr_flag_q, wdc_flag_q};
				OFS_STATUS: begin
					o_rdata <= 8'h00;
					o_rdata[STAT_TO_BIT] <= to_q;
					o_rdata[STAT_PDF_BIT] <= pdf_q;
				end
				default: o_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_por_release_state: assert property (@(posedge i_ref_clk)
		$fell(i_reset) |-> o_core_reset && o_por_active && thr_q == THR_POR && !to_q && !pdf_q)
		else $error("power-on did not leave defaults");

	a_por_hold_long: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$rose(o_core_reset) && cause_q != RSC_CAUSE_WDT |-> o_core_reset [*8])
		else $error("reset hold ended too early");

	a_lv_arms_reset: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		st_q == ST_RUN && thr_legal && wdc_legal && lv_hit |=> st_q == ST_ARM
		&& cause_q == RSC_CAUSE_LV)
		else $error("low supply did not arm reset");

	a_lv_filter_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		lv_hit |-> $past(i_supply_low, 1) && lv_cnt_q == FILT_W'(LV_FILTER_CYC))
		else $error("low supply accepted before filter time");

	a_bad_code_arms: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		st_q == ST_RUN && !thr_legal |=> st_q == ST_ARM && cause_q == RSC_CAUSE_THR)
		else $error("illegal threshold code not caught");

	a_thr_fault_restore: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		set_thr |=> thr_q == THR_POR && thr_flag_q && o_core_reset)
		else $error("threshold fault did not restore field");

	a_lv_keeps_thr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		set_lv && !thr_wr |=> thr_q == $past(thr_q) && lv_flag_q && o_core_reset)
		else $error("low supply reset changed threshold");

	a_powerdown_mask: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_powerdown |-> !lv_hit)
		else $error("low supply armed in power-down");

	a_rsvd_read_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_rd && i_addr == OFS_CAUSE_CTRL |=> o_rdata[6:4] == 3'h0)
		else $error("reserved cause bits not zero");

	a_lv_flag_no_set: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		ctrl_wr && !lv_flag_q && !set_lv |=> !lv_flag_q)
		else $error("software set low-voltage flag");

	a_wdt_full_reset: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wdt_full |=> o_core_reset && to_q && pdf_q == $past(pdf_q) && !o_por_active)
		else $error("watchdog full reset wrong");

	a_wdt_halt_partial: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wdt_halt |=> o_pc_sp_reset && to_q && pdf_q && !o_core_reset ##1 !o_pc_sp_reset)
		else $error("halted watchdog reset wrong");

	a_settle_bound: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		st_q == ST_SETTLE |-> hold_cnt_q < HOLD_W'(WAKE_SLOW_XTAL_CYC))
		else $error("wake settle count out of range");

	a_wdc_code_fault: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		set_wdc |=> wdc_flag_q && o_core_reset && st_q == ST_HOLD)
		else $error("watchdog code fault not handled");

	a_thr_flag_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!set_thr && !ctrl_wr |=> thr_flag_q == $past(thr_flag_q))
		else $error("threshold fault flag changed on its own");

	a_wdt_hold_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wdt_full |=> st_q == ST_HOLD && hold_cnt_q == HOLD_W'(WDT_HOLD_CYC - 1))
		else $error("watchdog hold not loaded");

	a_por_defaults_pulse: assert property (@(posedge i_ref_clk)
		$fell(i_reset) |-> o_por_defaults ##1 !o_por_defaults)
		else $error("power-on default pulse wrong");

	a_thr_write_lands: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		thr_wr && !set_thr |=> thr_q == $past(i_wdata))
		else $error("threshold write lost");

endmodule

`default_nettype wire

// [dv/rsc_partner.sv]
// Purpose: supply comparator and sub-clock source facing the reset block
// Assumes: one reference clock
// Notes:   sub-clock divider shrunk to 8 cycles to keep runs short

`timescale 1ns/1ps
`default_nettype none

module rsc_partner (
	input wire logic i_ref_clk,
	output logic o_sub_tick,
	output logic o_supply_low
);
	int unsigned div_q;
	initial begin
		div_q = 0;
		o_sub_tick = 1'b0;
		o_supply_low = 1'b0;
	end
	always @(posedge i_ref_clk) begin
		div_q <= (div_q + 1) % 8;
		o_sub_tick <= (div_q == 7);
	end
	// comparator reports low for n edges, then recovers
	task automatic dip(input int n);
		o_supply_low <= 1'b1;
		repeat (n) @(posedge i_ref_clk);
		#1;
		o_supply_low <= 1'b0;
	endtask
endmodule

`default_nettype wire

// [dv/test_reset_source_control.sv]
// Purpose: self-checking bench for rsc_top against an integer model
// Assumes: hold counts shrunk to 20 and 12 cycles
// Notes:   hold lengths accepted within one cycle of the count

`timescale 1ns/1ps
`default_nettype none

module test_reset_source_control;
	import rsc_pkg::*;
	localparam int PH = 20;
	localparam int WH = 12;
	localparam int SUB = 8;
	logic i_ref_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_powerdown = 1'b0, i_halt_mode = 1'b0, i_wdt_overflow = 1'b0, i_subclk_fault = 1'b0;
	logic [4:0] i_wdt_enable_code = WDC_ENABLE;
	rsc_wake_src_t i_wake_src = RSC_WAKE_FAST_INT;
	logic [7:0] o_rdata;
	logic [1:0] o_threshold_sel;
	logic i_sub_tick, i_supply_low, o_core_reset, o_por_active, o_por_defaults;
	logic o_pc_sp_reset, o_wake_hold, o_sysclk_keep_idle;
	int n_mismatch = 0, n_tests = 0, cycles = 0, w, n, seed = 32'h5996;
	logic [7:0] thr_m, cause_m, stat_m, c;
	logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
	int lo [4] = '{15, 15, 1024, 1};
	int hi [4] = '{16, 16, 1024, 2};

	rsc_partner p (.i_ref_clk(i_ref_clk), .o_sub_tick(i_sub_tick), .o_supply_low(i_supply_low));
	rsc_top #(.POR_HOLD_CYC(PH), .WDT_HOLD_CYC(WH)) dut (.i_ref_clk(i_ref_clk),
		.i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_sub_tick(i_sub_tick), .i_supply_low(i_supply_low),
		.i_powerdown(i_powerdown), .i_halt_mode(i_halt_mode), .i_wdt_overflow(i_wdt_overflow),
		.i_wdt_enable_code(i_wdt_enable_code), .i_subclk_fault(i_subclk_fault),
		.i_wake_src(i_wake_src), .o_core_reset(o_core_reset), .o_por_active(o_por_active),
		.o_por_defaults(o_por_defaults), .o_pc_sp_reset(o_pc_sp_reset),
		.o_wake_hold(o_wake_hold), .o_threshold_sel(o_threshold_sel),
		.o_sysclk_keep_idle(o_sysclk_keep_idle));

	// ------------------------------------------------------------
	// clock, watchdog on the run
	// ------------------------------------------------------------
	initial begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		cyc(1);
		i_wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
		i_rd <= 1'b1;
		i_addr <= a;
		cyc(1);
		i_rd <= 1'b0;
		chk(o_rdata, exp, nm);
		cyc(1);
	endtask
	task automatic rdall;
		rd(OFS_THRESHOLD, thr_m, "threshold");
		rd(OFS_CAUSE_CTRL, cause_m, "cause");
		rd(OFS_STATUS, stat_m, "status");
	endtask
	// waits for core reset, returns the wait, checks the hold length
	task automatic rst_seen(input int h, output int wt, input string nm);
		wt = 0;
		while (o_core_reset !== 1'b1 && wt < 200) begin
			cyc(1);
			wt++;
		end
		i_wdt_enable_code <= WDC_ENABLE;
		chk(8'(o_core_reset), 8'h01, nm);
		n = 0;
		while (o_core_reset === 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk(8'(n >= h - 1 && n <= h + 1), 8'h01, nm);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		thr_m = THR_POR;
		cause_m = 8'h00;
		stat_m = 8'h00;
		cyc(6);
		chk(8'(o_core_reset), 8'h01, "core reset in por");
		chk(8'(o_por_defaults), 8'h01, "por defaults");
		i_reset <= 1'b0;
		cyc(1);
		chk(8'(o_por_defaults), 8'h00, "por defaults pulse");
		chk(8'(o_por_active), 8'h01, "por active");
		rst_seen(PH - 1, w, "por hold");
		chk(8'(o_por_active), 8'h00, "por marker off");
		rdall();
		for (int i = 0; i < 4; i++) begin
			wr(OFS_THRESHOLD, codes[i]);
			rd(OFS_THRESHOLD, codes[i], "legal code");
			chk(8'(o_threshold_sel), 8'(i), "threshold select");
			chk(8'(o_core_reset), 8'h00, "no reset on legal");
		end
		p.dip(40);
		cyc(20);
		chk(8'(o_core_reset), 8'h00, "short dip");
		thr_m = 8'h99;
		wr(OFS_THRESHOLD, thr_m);
		fork
			p.dip(70);
			rst_seen(PH, w, "low supply reset");
		join
		cause_m[CTRL_LVF_BIT] = 1'b1;
		rdall();
		i_powerdown <= 1'b1;
		p.dip(70);
		cyc(5);
		chk(8'(o_core_reset), 8'h00, "powerdown mask");
		i_powerdown <= 1'b0;
		// software clear of bit2, then attempted set of every flag bit
		wr(OFS_CAUSE_CTRL, 8'hfb);
		cause_m = 8'h80;
		wr(OFS_CAUSE_CTRL, 8'h8f);
		chk(8'(o_sysclk_keep_idle), 8'h01, "keep idle bit");
		wr(OFS_STATUS, 8'hff);
		rdall();
		rd(2'h3, 8'h00, "unmapped");
		do c = 8'($random(seed)); while (c inside {8'h55, 8'h33, 8'h99, 8'haa});
		wr(OFS_THRESHOLD, c);
		rst_seen(PH, w, "bad threshold reset");
		chk(8'(w >= 2 * SUB && w <= 3 * SUB + 1), 8'h01, "bad threshold delay");
		thr_m = THR_POR;
		cause_m[CTRL_THRF_BIT] = 1'b1;
		rdall();
		do c = 8'($random(seed) & 32'h1f); while (c inside {8'h0a, 8'h15});
		i_wdt_enable_code <= c[4:0];
		rst_seen(PH, w, "bad watchdog code");
		chk(8'(w >= 2 * SUB && w <= 3 * SUB + 1), 8'h01, "bad watchdog delay");
		cause_m[CTRL_WDCF_BIT] = 1'b1;
		i_subclk_fault <= 1'b1;
		cyc(1);
		i_subclk_fault <= 1'b0;
		cause_m[CTRL_SUBF_BIT] = 1'b1;
		wr(OFS_CAUSE_CTRL, 8'h0d);
		cause_m = cause_m & 8'h0d;
		rdall();
		i_wdt_overflow <= 1'b1;
		cyc(1);
		i_wdt_overflow <= 1'b0;
		rst_seen(WH, w, "watchdog hold");
		chk(8'(o_por_active), 8'h00, "por marker wdt");
		stat_m = 8'h20;
		rdall();
		i_halt_mode <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			i_wake_src <= rsc_wake_src_t'(s);
			cyc(1);
			i_wdt_overflow <= 1'b1;
			cyc(1);
			i_wdt_overflow <= 1'b0;
			chk(8'(o_pc_sp_reset), 8'h01, "pc sp clear");
			chk(8'(o_core_reset), 8'h00, "no full reset");
			n = 0;
			while (o_wake_hold === 1'b1 && n < 2000) begin
				n++;
				cyc(1);
				if (n == 1) chk(8'(o_pc_sp_reset), 8'h00, "pc sp pulse");
			end
			chk(8'(n >= lo[s] && n <= hi[s]), 8'h01, "wake settle");
		end
		i_halt_mode <= 1'b0;
		stat_m = 8'h30;
		rdall();
		test_done();
	end
endmodule

`default_nettype wire
